// ### hw/tspm_top.sv
/*
 Single pulse timer with an AHB-Lite register slave.
 Assumes one master, single word transfers, hclk at 100 MHz.
*/
module tspm_top #(
   parameter int W = 10
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             timer_out,
   output logic             compare_a_irq_flag
);
   // elaboration check: the register map only serves a ten bit timer
   if (W != 10) begin : g_bad_width
      $error("tspm_top: register map holds a ten bit timer");
   end

   typedef struct packed {
      logic         wr_pend;
      logic [11:0]  addr;
      logic         timer_run_bit;
      logic         counter_clear_select;
      logic [1:0]   output_ctrl;
      logic [1:0]   timer_mode_sel;
      logic [W-1:0] compare_reg_a;
      logic [W-1:0] compare_reg_p;
      logic         flag;
      logic [31:0]  rdata;
   } tspm_regs_st_t;

   tspm_regs_st_t st_reg, st_next;
   tspm_cnt_if #(.W(W)) cif ();

   // ----------------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------------
   function automatic logic [31:0] rd_word(input tspm_regs_st_t s, input logic [11:0] a,
                                           input logic [W-1:0] cnt);
      logic [31:0] r;
      r = tspm_pkg::RDATA_RST;
      unique case (a)
         tspm_pkg::CTRL_OFS: begin
            r[tspm_pkg::RUN_POS]                  = s.timer_run_bit;
            r[tspm_pkg::CCLR_POS]                 = s.counter_clear_select;
            r[tspm_pkg::OCTRL_LO+:2]              = s.output_ctrl;
            r[tspm_pkg::MODE_LO+:2]               = s.timer_mode_sel;
         end
         tspm_pkg::CMPA_OFS:   r[W-1:0] = s.compare_reg_a;
         tspm_pkg::CMPP_OFS:   r[W-1:0] = s.compare_reg_p;
         tspm_pkg::COUNT_OFS:  r[W-1:0] = cnt;
         tspm_pkg::STATUS_OFS: r[tspm_pkg::FLAG_POS] = s.flag;
         default:              r = tspm_pkg::RDATA_RST;     // unmapped reads zero
      endcase
      return r;
   endfunction : rd_word

   // ----------------------------------------------------------------------
   // bus slave and register state
   // ----------------------------------------------------------------------
   // zero wait state: writes land in the data phase, reads are registered
   // in the address phase so hrdata is valid in the data phase
   logic acc;
   assign acc = hsel && hready && htrans[1];

   always_comb begin
      st_next         = st_reg;
      st_next.wr_pend = acc && hwrite;
      if (acc) begin
         st_next.addr = {haddr[11:2], 2'b00};
      end
      if (acc && !hwrite) begin
         st_next.rdata = rd_word(st_reg, {haddr[11:2], 2'b00}, cif.count);
      end
      if (st_reg.wr_pend) begin
         unique case (st_reg.addr)
            tspm_pkg::CTRL_OFS: begin
               st_next.timer_run_bit        = hwdata[tspm_pkg::RUN_POS];
               st_next.counter_clear_select = hwdata[tspm_pkg::CCLR_POS];
               st_next.output_ctrl          = hwdata[tspm_pkg::OCTRL_LO+:2];
               st_next.timer_mode_sel       = hwdata[tspm_pkg::MODE_LO+:2];
            end
            tspm_pkg::CMPA_OFS: st_next.compare_reg_a = hwdata[W-1:0];
            tspm_pkg::CMPP_OFS: st_next.compare_reg_p = hwdata[W-1:0];
            tspm_pkg::STATUS_OFS: begin
               if (hwdata[tspm_pkg::FLAG_POS]) st_next.flag = 1'b0;
            end
            default: ;
         endcase
      end
      // hardware wins over a software write in the same cycle
      if (cif.match) begin
         st_next.timer_run_bit = 1'b0;
         st_next.flag          = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------------
   // core hookup and outputs
   // ----------------------------------------------------------------------
   assign cif.run    = st_reg.timer_run_bit;
   assign cif.cmp_a  = st_reg.compare_reg_a;
   // output control must read 11 for the pin to be driven in this mode
   assign cif.single = (st_reg.timer_mode_sel == tspm_pkg::MODE_SINGLE) &&
                       (st_reg.output_ctrl == tspm_pkg::OCTRL_SINGLE);

   tspm_core #(.W(W)) u_core (
      .hclk    (hclk),
      .hresetn (hresetn),
      .cif     (cif.core)
   );

   assign hrdata             = st_reg.rdata;
   assign hreadyout          = 1'b1;
   assign hresp              = 1'b0;
   assign timer_out          = cif.pulse;
   assign compare_a_irq_flag = st_reg.flag;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   // the edge after a match: run low, flag up, pin low
   property p_match_clears_run;
      @(posedge hclk) disable iff (!hresetn)
      cif.match |=> (!st_reg.timer_run_bit && st_reg.flag && !timer_out);
   endproperty
   a_match_clears_run: assert property (p_match_clears_run) else $error("match did not end pulse");

   // only hardware raises the flag
   property p_flag_set;
      @(posedge hclk) disable iff (!hresetn)
      $rose(st_reg.flag) |-> $past(cif.match);
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag set without match");

   property p_run_low_no_pulse;
      @(posedge hclk) disable iff (!hresetn)
      $fell(st_reg.timer_run_bit) |=> !timer_out;
   endproperty
   a_run_low_no_pulse: assert property (p_run_low_no_pulse) else $error("pulse outlived run");

   sequence s_start;
      cif.single && $rose(st_reg.timer_run_bit);
   endsequence
   property p_start_pulse;
      @(posedge hclk) disable iff (!hresetn)
      s_start |=> timer_out;
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("no leading edge");

   // a stable run bit cannot restart; a fresh rising run may legally retrigger
   property p_no_retrigger;
      @(posedge hclk) disable iff (!hresetn)
      ($fell(timer_out) && $stable(st_reg.timer_run_bit) && st_reg.timer_run_bit)
         |=> !timer_out;
   endproperty
   a_no_retrigger: assert property (p_no_retrigger) else $error("pulse repeated");

   // a control write lands one edge after its data phase; a match only touches run and the flag
   property p_ctrl_lands;
      @(posedge hclk) disable iff (!hresetn)
      (st_reg.wr_pend && st_reg.addr == tspm_pkg::CTRL_OFS) |=>
         (st_reg.timer_mode_sel == $past(hwdata[tspm_pkg::MODE_LO+:2]) &&
          st_reg.output_ctrl == $past(hwdata[tspm_pkg::OCTRL_LO+:2]));
   endproperty
   a_ctrl_lands: assert property (p_ctrl_lands) else $error("control write lost");

   // the flag stays up until software writes a one to clear it
   property p_flag_sticky;
      @(posedge hclk) disable iff (!hresetn)
      (st_reg.flag && !(st_reg.wr_pend && st_reg.addr == tspm_pkg::STATUS_OFS &&
                        hwdata[tspm_pkg::FLAG_POS])) |=> st_reg.flag;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped by itself");

   // a count read returns the count seen in its address phase, upper bits zero
   property p_count_read;
      @(posedge hclk) disable iff (!hresetn)
      (acc && !hwrite && haddr[11:2] == tspm_pkg::COUNT_OFS[11:2]) |=>
         ((hrdata[W-1:0] == $past(cif.count)) && (hrdata[31:W] == '0));
   endproperty
   a_count_read: assert property (p_count_read) else $error("count read wrong");

   // compare-a reads back what was stored, upper bits zero
   property p_cmpa_read;
      @(posedge hclk) disable iff (!hresetn)
      (acc && !hwrite && haddr[11:2] == tspm_pkg::CMPA_OFS[11:2]) |=>
         ((hrdata[W-1:0] == $past(st_reg.compare_reg_a)) && (hrdata[31:W] == '0));
   endproperty
   a_cmpa_read: assert property (p_cmpa_read) else $error("compare-a read wrong");
endmodule : tspm_top

// ### hw/tspm_pkg.sv
/*
 Package for the single pulse timer: register offsets, field positions,
 reset values and mode encodings.
 Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
*/
package tspm_pkg;
   // ----------------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------------
   localparam logic [11:0] CTRL_OFS    = 12'h000; // timer_control_1
   localparam logic [11:0] CMPA_OFS    = 12'h004; // compare_reg_a
   localparam logic [11:0] CMPP_OFS    = 12'h008; // compare_reg_p
   localparam logic [11:0] COUNT_OFS   = 12'h00C; // counter, read only
   localparam logic [11:0] STATUS_OFS  = 12'h010; // flag, write one to clear

   // ----------------------------------------------------------------------
   // timer_control_1 and status field positions
   // ----------------------------------------------------------------------
   localparam int RUN_POS     = 0;
   localparam int CCLR_POS    = 1;
   localparam int OCTRL_LO    = 4;
   localparam int MODE_LO     = 6;
   localparam int FLAG_POS    = 0;

   localparam logic [1:0] MODE_SINGLE  = 2'h2;
   localparam logic [1:0] OCTRL_SINGLE = 2'h3;

   localparam logic [9:0]  COUNT_RST = 10'h000;
   localparam logic [9:0]  CMP_RST   = 10'h000;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;

   typedef enum logic [1:0] {TSPM_IDLE, TSPM_RUN, TSPM_STOP} tspm_state_t;
endpackage : tspm_pkg

// ### hw/tspm_cnt_if.sv
/*
 Interface between the register front end and the counter core.
 Assumes both ends run on the same hclk.
*/
interface tspm_cnt_if #(parameter int W = 10);
   logic         run;        // run bit as software holds it
   logic         single;     // single pulse mode and output control 11 both selected
   logic [W-1:0] cmp_a;
   logic [W-1:0] count;
   logic         match;      // one-cycle pulse on compare-a match
   logic         pulse;

   modport regs (output run, output single, output cmp_a,
                 input count, input match, input pulse);
   modport core (input run, input single, input cmp_a,
                 output count, output match, output pulse);
endinterface : tspm_cnt_if

// ### hw/tspm_core.sv
/*
 Counter core of the single pulse timer: counts while running, stops on a
 compare-a match in single pulse mode with output control 11, drives the pulse.
 Assumes run and cmp_a come from logic on the same clock.
*/
module tspm_core #(
   parameter int W = 10
) (
   input  wire logic  hclk,
   input  wire logic  hresetn,
   tspm_cnt_if.core   cif
);
   // elaboration check: compare and count logic is sized for 2 to 16 bits
   if (W < 2 || W > 16) begin : g_bad_width
      $error("tspm_core: W out of range");
   end

   typedef struct packed {
      logic         run_d;
      logic         going;
      logic [W-1:0] count;
      logic         match;
   } tspm_core_st_t;

   tspm_core_st_t st_reg, st_next;

   // ----------------------------------------------------------------------
   // counter state
   // ----------------------------------------------------------------------
   // restart only on a rising run bit; a p match or clear select never enter here
   always_comb begin
      st_next       = st_reg;
      st_next.match = 1'b0;
      st_next.run_d = cif.run;
      if (cif.run && !st_reg.run_d) begin
         st_next.count = '0;
         st_next.going = 1'b1;
      end else if (!cif.run) begin
         st_next.going = 1'b0;
      end else if (st_reg.going && cif.single && st_reg.count == cif.cmp_a) begin
         st_next.going = 1'b0;
         st_next.match = 1'b1;
      end else if (st_reg.going) begin
         st_next.count = st_reg.count + 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign cif.count = st_reg.count;
   assign cif.match = st_reg.match;
   assign cif.pulse = st_reg.going && cif.single;

   // a match ends counting in the same step
   property p_match_stops;
      @(posedge hclk) disable iff (!hresetn)
      st_reg.match |-> !st_reg.going ##1 (!st_reg.going && $stable(st_reg.count));
   endproperty
   a_match_stops: assert property (p_match_stops) else $error("count kept running");

   property p_restart_zero;
      @(posedge hclk) disable iff (!hresetn)
      (cif.run && !st_reg.run_d) |=> (st_reg.count == '0 && st_reg.going);
   endproperty
   a_restart_zero: assert property (p_restart_zero) else $error("restart not at zero");

   property p_hold_stopped;
      @(posedge hclk) disable iff (!hresetn)
      (!st_reg.going && !(cif.run && !st_reg.run_d)) |=> $stable(st_reg.count);
   endproperty
   a_hold_stopped: assert property (p_hold_stopped) else $error("stopped count moved");
endmodule : tspm_core

// ### test/tspm_pulse_mon.sv
/*
 Far-side model: the circuit that listens to the timer output pin.
 Assumes the pin is a clean level sampled on hclk.
*/
module tspm_pulse_mon (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        pin,
   output logic      [15:0] width,
   output logic      [15:0] pulses
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] run_len;

   // ---------------------------------------------------------------
   // pulse measurement
   // ---------------------------------------------------------------
   // width is the high time in cycles, latched at the falling edge, so a
   // second pulse shows up as a count change and a stuck-high pin as no count
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_len <= 16'h0000;
         width   <= 16'h0000;
         pulses  <= 16'h0000;
      end else if (pin) begin
         run_len <= run_len + 16'h0001;
      end else if (run_len != 16'h0000) begin
         width   <= run_len;
         pulses  <= pulses + 16'h0001;
         run_len <= 16'h0000;
      end
   end
endmodule : tspm_pulse_mon

// ### test/tspm_top_tb.sv
/*
 Self-checking bench for the single pulse timer.
 Assumes a zero-wait AHB-Lite slave and the far-side pulse monitor.
*/
module tspm_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000, hrdata, rd, keep;
   logic hreadyout, hresp, timer_out, flag;
   logic [15:0] width, pulses;
   int n_errors = 0, checked = 0;

   tspm_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .timer_out(timer_out), .compare_a_irq_flag(flag));
   tspm_pulse_mon mon_u (.hclk(hclk), .hresetn(hresetn), .pin(timer_out),
      .width(width), .pulses(pulses));

   always #5 hclk = ~hclk;

   // ---------------------------------------------------------------
   // bus and check helpers
   // ---------------------------------------------------------------
   task wrap_up;
      if (n_errors == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : wrap_up
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   // waits for hready at a rising edge; a hung slave ends the run
   task wait_rdy;
      int i;
      i = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         i++;
         if (i > 100) begin
            n_errors++;
            wrap_up();
         end
         @(posedge hclk);
      end
   endtask : wait_rdy
   task ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask : ahb
   // mode 10 and output control 11 held in every control word ctl builds
   function automatic logic [31:0] ctl(input logic cclr, input logic run);
      return {24'h0, tspm_pkg::MODE_SINGLE, tspm_pkg::OCTRL_SINGLE, 2'h0, cclr, run};
   endfunction : ctl
   task wait_pulse(input logic [15:0] n);
      int i;
      for (i = 0; i < 3000 && pulses !== n; i++) @(posedge hclk);
      if (pulses !== n) begin
         n_errors++;
         wrap_up();
      end
   endtask : wait_pulse

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task t_reset;
      chk({31'h0, timer_out}, 32'h0);
      ahb(1'b0, tspm_pkg::COUNT_OFS, 32'h0);
      chk(rd, 32'h0);
      ahb(1'b0, tspm_pkg::CMPA_OFS, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, hresp}, 32'h0);
   endtask : t_reset
   // compare-p below compare-a and clear select set must change nothing
   task t_match_stop;
      ahb(1'b1, tspm_pkg::CMPA_OFS, 32'h0000_0005);
      ahb(1'b1, tspm_pkg::CMPP_OFS, 32'h0000_0002);
      ahb(1'b1, tspm_pkg::CTRL_OFS, ctl(1'b1, 1'b1));
      wait_pulse(16'h0001);
      chk({16'h0, width}, 32'h6);
      chk({31'h0, flag}, 32'h1);
      ahb(1'b0, tspm_pkg::CTRL_OFS, 32'h0);
      chk(rd, ctl(1'b1, 1'b0));
      repeat (20) @(posedge hclk);
      ahb(1'b0, tspm_pkg::COUNT_OFS, 32'h0);
      chk(rd, 32'h5);
      chk({16'h0, pulses}, 32'h1);
   endtask : t_match_stop
   // software ends the pulse long before a far compare value
   task t_soft_stop;
      ahb(1'b1, tspm_pkg::STATUS_OFS, 32'h1);
      ahb(1'b1, tspm_pkg::CMPA_OFS, 32'hFFFF_FFFF);
      ahb(1'b0, tspm_pkg::CMPA_OFS, 32'h0);
      chk(rd, 32'h3FF);
      ahb(1'b1, tspm_pkg::CTRL_OFS, ctl(1'b0, 1'b1));
      ahb(1'b0, tspm_pkg::COUNT_OFS, 32'h0);
      chk({31'h0, rd < 32'h8}, 32'h1);
      repeat (10) @(posedge hclk);
      ahb(1'b1, tspm_pkg::CTRL_OFS, ctl(1'b0, 1'b0));
      wait_pulse(16'h0002);
      ahb(1'b0, tspm_pkg::COUNT_OFS, 32'h0);
      keep = rd;
      repeat (10) @(posedge hclk);
      ahb(1'b0, tspm_pkg::COUNT_OFS, 32'h0);
      chk(rd, keep);
      chk({31'h0, flag}, 32'h0);
   endtask : t_soft_stop
   // mode 00 with output control 11 must leave the pin low even with run high
   task t_other_mode;
      ahb(1'b1, tspm_pkg::CTRL_OFS, {24'h0, 2'h0, tspm_pkg::OCTRL_SINGLE, 4'h1});
      repeat (20) @(posedge hclk);
      chk({31'h0, timer_out}, 32'h0);
      chk({16'h0, pulses}, 32'h2);
      ahb(1'b1, tspm_pkg::CTRL_OFS, 32'h0);
      repeat (4) @(posedge hclk);
      chk({16'h0, pulses}, 32'h2);
   endtask : t_other_mode

   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_match_stop();
      t_soft_stop();
      t_other_mode();
      wrap_up();
   end
endmodule : tspm_top_tb
